// ==== logic/pel_pkg.sv ====
// constants for the probe edge position latch
package pel_pkg;
    localparam int NUM_PROBES = 2;
    localparam int POS_W = 32;
    localparam int IDX_W = 16;
    localparam int WORD_W = 16;
    // object indices
    localparam logic [15:0] IDX_PROBE_CTRL = 16'h60B8;
    localparam logic [15:0] IDX_PROBE_STAT = 16'h60B9;
    localparam logic [15:0] IDX_P1_RISE = 16'h60BA;
    localparam logic [15:0] IDX_P1_FALL = 16'h60BB;
    localparam logic [15:0] IDX_P2_RISE = 16'h60BC;
    localparam logic [15:0] IDX_P2_FALL = 16'h60BD;
    // per-probe field offsets inside control and status words
    localparam int PROBE_STRIDE = 8;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_CONT = 1;
    localparam int CTRL_SEL = 2;
    localparam int CTRL_RISE_EN = 4;
    localparam int CTRL_FALL_EN = 5;
    localparam int STAT_ENABLED = 0;
    localparam int STAT_RISE = 1;
    localparam int STAT_FALL = 2;
    localparam int STAT_SEL = 6;
    localparam int STAT_LEVEL = 7;
    // writable control bits, everything else reads as zero
    localparam logic [15:0] CTRL_MASK = 16'h3737;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [31:0] POS_RESET = 32'h00000000;
    localparam logic SEL_DIGITAL = 1'b0;
    localparam logic SEL_INDEX = 1'b1;
endpackage

// ==== logic/pel_edge_capture.sv ====
// one probe: edge detection and rising/falling position capture
`timescale 1ns/100ps
module pel_edge_capture (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic ce, // clock enable
    input wire logic trig, // selected trigger level
    input wire logic enable, // probe enabled
    input wire logic continuous, // 1 = capture every edge, 0 = first only
    input wire logic rise_en, // capture on rising edge
    input wire logic fall_en, // capture on falling edge
    input wire logic signed [31:0] position, // raw encoder count
    output logic signed [31:0] rise_pos, // rising-edge capture
    output logic signed [31:0] fall_pos, // falling-edge capture
    output logic rise_flag, // rising capture done
    output logic fall_flag // falling capture done
);
    logic prev_ff, nxt_prev;
    logic signed [31:0] rise_pos_ff, nxt_rise_pos, fall_pos_ff, nxt_fall_pos;
    logic rise_flag_ff, nxt_rise_flag, fall_flag_ff, nxt_fall_flag;
    logic rise_hit, fall_hit;

    // ----------------------------------------
    // edge detection and capture
    // ----------------------------------------
    always_comb
    begin
        rise_hit = trig & ~prev_ff & enable & rise_en & (continuous | ~rise_flag_ff);
        fall_hit = ~trig & prev_ff & enable & fall_en & (continuous | ~fall_flag_ff);
        nxt_prev = trig;
        nxt_rise_pos = rise_hit ? position : rise_pos_ff;
        nxt_fall_pos = fall_hit ? position : fall_pos_ff;
        // disabling the probe clears its flags and rearms single mode
        nxt_rise_flag = enable & (rise_flag_ff | rise_hit);
        nxt_fall_flag = enable & (fall_flag_ff | fall_hit);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prev_ff <= 1'b0;
            rise_pos_ff <= pel_pkg::POS_RESET;
            fall_pos_ff <= pel_pkg::POS_RESET;
            rise_flag_ff <= 1'b0;
            fall_flag_ff <= 1'b0;
        end
        else if (ce)
        begin
            prev_ff <= nxt_prev;
            rise_pos_ff <= nxt_rise_pos;
            fall_pos_ff <= nxt_fall_pos;
            rise_flag_ff <= nxt_rise_flag;
            fall_flag_ff <= nxt_fall_flag;
        end
    end

    assign rise_pos = rise_pos_ff;
    assign fall_pos = fall_pos_ff;
    assign rise_flag = rise_flag_ff;
    assign fall_flag = fall_flag_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_rise_edge;
        ce && enable && rise_en && !prev_ff && trig && (continuous || !rise_flag_ff);
    endsequence

    sequence s_fall_edge;
        ce && enable && fall_en && prev_ff && !trig && (continuous || !fall_flag_ff);
    endsequence

    a_rise_capture: assert property (s_rise_edge |=> rise_pos_ff == $past(position) && rise_flag_ff)
        else $error("rising edge did not capture position");
    a_fall_capture: assert property (s_fall_edge |=> fall_pos_ff == $past(position) && fall_flag_ff)
        else $error("falling edge did not capture position");
    a_value_held: assert property (!(ce && trig && !prev_ff && enable && rise_en) |=> $stable(rise_pos_ff))
        else $error("rising capture changed without an enabled edge");
    a_single_shot: assert property (ce && !continuous && fall_flag_ff && enable |=> $stable(fall_pos_ff))
        else $error("single mode overwrote a falling capture");
    a_flag_clear: assert property (ce && !enable |=> !rise_flag_ff && !fall_flag_ff)
        else $error("flags not cleared by disabled probe");
endmodule

// ==== logic/pel_probe_latch.sv ====
// touch-probe position latch: two probes, object access port
`timescale 1ns/100ps
module pel_probe_latch (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic signed [31:0] enc_position, // raw encoder count
    input wire logic enc_index, // encoder index pulse
    input wire logic probe1_digital_input, // probe 1 digital input
    input wire logic probe2_digital_input, // probe 2 digital input
    input wire logic obj_valid, // object access request
    input wire logic obj_write, // 1 = write, 0 = read
    input wire logic [15:0] obj_index, // object index
    input wire logic [31:0] obj_wdata, // write data
    output logic [31:0] obj_rdata, // read data
    output logic obj_ack, // access done, one-cycle pulse
    output logic obj_err // access refused, with ack
);
    logic [15:0] ctrl_ff, nxt_ctrl;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ack_ff, nxt_ack;
    logic err_ff, nxt_err;
    logic [15:0] status_word;
    logic [1:0] din;
    logic [1:0] trig;
    logic [1:0] rise_flag;
    logic [1:0] fall_flag;
    logic signed [31:0] rise_pos [2];
    logic signed [31:0] fall_pos [2];

    // ----------------------------------------
    // object decode
    // ----------------------------------------
    function automatic logic obj_known(input logic [15:0] idx);
        obj_known = (idx >= pel_pkg::IDX_PROBE_CTRL) && (idx <= pel_pkg::IDX_P2_FALL);
    endfunction

    function automatic logic obj_writable(input logic [15:0] idx);
        obj_writable = (idx == pel_pkg::IDX_PROBE_CTRL);
    endfunction

    function automatic logic ctrl_bit(input logic [15:0] w, input int p, input int f);
        ctrl_bit = w[p * pel_pkg::PROBE_STRIDE + f];
    endfunction

    assign din = {probe2_digital_input, probe1_digital_input};

    // ----------------------------------------
    // probes
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < pel_pkg::NUM_PROBES; g++)
        begin : g_probe
            // trigger source select
            assign trig[g] = (ctrl_bit(ctrl_ff, g, pel_pkg::CTRL_SEL) == pel_pkg::SEL_INDEX)
                ? enc_index : din[g];

            pel_edge_capture u_cap (
                .clk(clk),
                .rst(rst),
                .ce(ce),
                .trig(trig[g]),
                .enable(ctrl_bit(ctrl_ff, g, pel_pkg::CTRL_ENABLE)),
                .continuous(ctrl_bit(ctrl_ff, g, pel_pkg::CTRL_CONT)),
                .rise_en(ctrl_bit(ctrl_ff, g, pel_pkg::CTRL_RISE_EN)),
                .fall_en(ctrl_bit(ctrl_ff, g, pel_pkg::CTRL_FALL_EN)),
                .position(enc_position),
                .rise_pos(rise_pos[g]),
                .fall_pos(fall_pos[g]),
                .rise_flag(rise_flag[g]),
                .fall_flag(fall_flag[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // status word
    // ----------------------------------------
    always_comb
    begin
        status_word = '0;
        for (int p = 0; p < pel_pkg::NUM_PROBES; p++)
        begin
            status_word[p * pel_pkg::PROBE_STRIDE + pel_pkg::STAT_ENABLED] =
                ctrl_bit(ctrl_ff, p, pel_pkg::CTRL_ENABLE);
            status_word[p * pel_pkg::PROBE_STRIDE + pel_pkg::STAT_RISE] = rise_flag[p];
            status_word[p * pel_pkg::PROBE_STRIDE + pel_pkg::STAT_FALL] = fall_flag[p];
            status_word[p * pel_pkg::PROBE_STRIDE + pel_pkg::STAT_SEL] =
                ctrl_bit(ctrl_ff, p, pel_pkg::CTRL_SEL);
            status_word[p * pel_pkg::PROBE_STRIDE + pel_pkg::STAT_LEVEL] = trig[p];
        end
    end

    // ----------------------------------------
    // object access
    // ----------------------------------------
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_rdata = rdata_ff;
        nxt_ack = obj_valid;
        nxt_err = 1'b0;
        if (obj_valid)
        begin
            if (!obj_known(obj_index))
            begin
                nxt_err = 1'b1;
                nxt_rdata = '0;
            end
            else if (obj_write)
            begin
                // captures and status refuse writes
                if (obj_writable(obj_index))
                    nxt_ctrl = obj_wdata[15:0] & pel_pkg::CTRL_MASK;
                else
                    nxt_err = 1'b1;
            end
            else
            begin
                case (obj_index)
                    pel_pkg::IDX_PROBE_CTRL: nxt_rdata = {16'h0000, ctrl_ff};
                    pel_pkg::IDX_PROBE_STAT: nxt_rdata = {16'h0000, status_word};
                    pel_pkg::IDX_P1_RISE: nxt_rdata = rise_pos[0];
                    pel_pkg::IDX_P1_FALL: nxt_rdata = fall_pos[0];
                    pel_pkg::IDX_P2_RISE: nxt_rdata = rise_pos[1];
                    pel_pkg::IDX_P2_FALL: nxt_rdata = fall_pos[1];
                    default: nxt_rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_ff <= pel_pkg::CTRL_RESET;
            rdata_ff <= pel_pkg::POS_RESET;
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end
        else if (ce)
        begin
            ctrl_ff <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
            err_ff <= nxt_err;
        end
    end

    assign obj_rdata = rdata_ff;
    assign obj_ack = ack_ff;
    assign obj_err = err_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_read(logic [15:0] idx);
        ce && obj_valid && !obj_write && obj_index == idx;
    endsequence

    a_read_p1_rise: assert property (s_read(pel_pkg::IDX_P1_RISE)
        |=> obj_ack && obj_rdata == $past(rise_pos[0]))
        else $error("probe 1 rising capture misread");
    a_read_p2_fall: assert property (s_read(pel_pkg::IDX_P2_FALL)
        |=> obj_ack && obj_rdata == $past(fall_pos[1]))
        else $error("probe 2 falling capture misread");
    a_ro_refused: assert property (ce && obj_valid && obj_write
        && obj_index >= pel_pkg::IDX_P1_RISE && obj_index <= pel_pkg::IDX_P2_FALL
        |=> obj_ack && obj_err && $stable(ctrl_ff))
        else $error("write to capture object not refused");
    a_status_flags: assert property (status_word[pel_pkg::STAT_RISE] == rise_flag[0]
        && status_word[pel_pkg::PROBE_STRIDE + pel_pkg::STAT_FALL] == fall_flag[1]
        && status_word[pel_pkg::PROBE_STRIDE + pel_pkg::STAT_ENABLED]
        == ctrl_ff[pel_pkg::PROBE_STRIDE + pel_pkg::CTRL_ENABLE])
        else $error("status word does not track flags");
    a_trig_select: assert property (trig[1] == (ctrl_ff[pel_pkg::PROBE_STRIDE + pel_pkg::CTRL_SEL]
        ? enc_index : probe2_digital_input))
        else $error("probe 2 trigger source wrong");
    a_ack_single: assert property (ce && !obj_valid |=> !obj_ack ##1 (obj_ack -> $past(obj_valid)))
        else $error("ack without request");
    a_ctrl_write: assert property (ce && obj_valid && obj_write
        && obj_index == pel_pkg::IDX_PROBE_CTRL
        |=> ctrl_ff == ($past(obj_wdata[15:0]) & pel_pkg::CTRL_MASK) && !obj_err)
        else $error("control word write lost");
endmodule

// ==== test/pel_master_model.sv ====
// object-port master model: one request at a time, driven at the falling edge
`timescale 1ns/100ps
module pel_master_model (
    input wire logic clk, // system clock
    output logic obj_valid, // access request
    output logic obj_write, // 1 = write
    output logic [15:0] obj_index, // object index
    output logic [31:0] obj_wdata, // write data
    input wire logic [31:0] obj_rdata, // read data
    input wire logic obj_ack, // access done
    input wire logic obj_err // access refused
);
    initial
    begin
        obj_valid = 1'b0;
        obj_write = 1'b0;
        obj_index = 16'h0000;
        obj_wdata = 32'h00000000;
    end

    // one request cycle, then wait a bounded time for the answer
    task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                          output logic [31:0] rd, output logic er);
        bit got;
        got = 0;
        // a missing answer leaves unknown data, which every compare refuses
        rd = 32'hXXXXXXXX;
        er = 1'bx;
        @(negedge clk);
        obj_valid = 1'b1;
        obj_write = wr;
        obj_index = idx;
        obj_wdata = wd;
        for (int i = 0; i < 4 && !got; i++)
        begin
            @(negedge clk);
            obj_valid = 1'b0;
            // released lines do not keep the last value
            obj_index = ~idx;
            obj_wdata = ~wd;
            if (obj_ack === 1'b1)
            begin
                got = 1;
                rd = obj_rdata;
                er = obj_err;
            end
        end
    endtask
endmodule

// ==== test/pel_probe_latch_tb.sv ====
// self-checking bench for the probe edge position latch
`timescale 1ns/100ps
module pel_probe_latch_tb;
    logic clk, rst, ce, enc_index, p1, p2, obj_valid, obj_write, obj_ack, obj_err, err;
    logic signed [31:0] pos;
    logic [15:0] obj_index;
    logic [31:0] obj_wdata, obj_rdata, rdata;
    logic [31:0] exp_cap [4];
    logic [3:0] flg;
    int error_cnt = 0;
    int comparisons = 0;

    pel_probe_latch pel_probe_latch_i (.clk(clk), .rst(rst), .ce(ce), .enc_position(pos),
        .enc_index(enc_index), .probe1_digital_input(p1), .probe2_digital_input(p2),
        .obj_valid(obj_valid), .obj_write(obj_write), .obj_index(obj_index),
        .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));
    pel_master_model pel_master_model_i (.clk(clk), .obj_valid(obj_valid),
        .obj_write(obj_write), .obj_index(obj_index), .obj_wdata(obj_wdata),
        .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [15:0] idx);
        pel_master_model_i.access(1'b0, idx, 32'h00000000, rdata, err);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        pel_master_model_i.access(1'b1, idx, wd, rdata, err);
    endtask

    // drive probe levels and position; expected captures follow the level changes
    task automatic step(input logic n1, input logic n2, input logic [31:0] np);
        @(negedge clk);
        pos = np;
        if (n1 !== p1)
        begin
            exp_cap[n1 ? 0 : 1] = np;
            flg[n1 ? 0 : 1] = 1'b1;
        end
        if (n2 !== p2)
        begin
            exp_cap[n2 ? 2 : 3] = np;
            flg[n2 ? 2 : 3] = 1'b1;
        end
        p1 = n1;
        p2 = n2;
    endtask

    function automatic logic [31:0] exp_stat();
        return {16'h0000, p2, 4'h0, flg[3], flg[2], 1'b1, p1, 4'h0, flg[1], flg[0], 1'b1};
    endfunction

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #100000;
        error_cnt++;
        end_sim();
    end

    initial
    begin
        logic [31:0] a, b;
        rst = 1'b1;
        ce = 1'b1;
        enc_index = 1'b0;
        p1 = 1'b0;
        p2 = 1'b0;
        pos = 32'h00000000;
        flg = 4'h0;
        for (int i = 0; i < 4; i++) exp_cap[i] = 32'h00000000;
        void'($urandom(32'h903B));
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        // reset values and refused writes
        for (int i = 0; i < 4; i++)
        begin
            wr(pel_pkg::IDX_P1_RISE + 16'(i), 32'h12345678);
            check({31'h0, err}, 32'h00000001);
            rd(pel_pkg::IDX_P1_RISE + 16'(i));
            check(rdata, 32'h00000000);
        end
        $display("test reset_and_readonly done");
        // both probes, both edges, continuous, random traffic with range corners
        wr(pel_pkg::IDX_PROBE_CTRL, 32'h00003333);
        for (int k = 0; k < 6; k++)
        begin
            step(1'b1, 1'b1, 32'h80000000);
            step(1'b0, 1'b0, 32'h7FFFFFFF);
            for (int j = 0; j < 12; j++)
                step(1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)), $urandom);
            rd(pel_pkg::IDX_P1_RISE);
            check(rdata, exp_cap[0]);
            rd(pel_pkg::IDX_P1_FALL);
            check(rdata, exp_cap[1]);
            rd(pel_pkg::IDX_P2_RISE);
            check(rdata, exp_cap[2]);
            rd(pel_pkg::IDX_P2_FALL);
            check(rdata, exp_cap[3]);
            rd(pel_pkg::IDX_PROBE_STAT);
            check(rdata, exp_stat());
        end
        $display("test random_capture done");
        // probe 1 on the index pulse; its digital input must be ignored
        step(1'b0, 1'b0, 32'h00000001);
        wr(pel_pkg::IDX_PROBE_CTRL, 32'h00000017);
        a = $urandom;
        @(negedge clk);
        pos = a;
        enc_index = 1'b1;
        @(negedge clk);
        pos = ~a;
        p1 = 1'b1;
        rd(pel_pkg::IDX_P1_RISE);
        check(rdata, a);
        rd(pel_pkg::IDX_PROBE_STAT);
        check(rdata & 32'h00000041, 32'h00000041);
        $display("test index_select done");
        // disable clears flags; single mode keeps only the first edge
        @(negedge clk);
        enc_index = 1'b0;
        p1 = 1'b0;
        wr(pel_pkg::IDX_PROBE_CTRL, 32'h00000000);
        rd(pel_pkg::IDX_PROBE_STAT);
        check(rdata, 32'h00000000);
        wr(pel_pkg::IDX_PROBE_CTRL, 32'h00000011);
        a = $urandom;
        b = ~a;
        step(1'b1, 1'b0, a);
        step(1'b0, 1'b0, 32'h00000005);
        step(1'b1, 1'b0, b);
        rd(pel_pkg::IDX_P1_RISE);
        check(rdata, a);
        rd(pel_pkg::IDX_PROBE_STAT);
        check(rdata, 32'h00000083);
        rd(16'h60BE);
        check({31'h0, err}, 32'h00000001);
        check(rdata, 32'h00000000);
        $display("test single_mode done");
        // clock enable low freezes the edge detector and the captures
        wr(pel_pkg::IDX_PROBE_CTRL, 32'h00000033);
        a = $urandom;
        b = ~a;
        step(1'b0, 1'b0, a);
        step(1'b1, 1'b0, b);
        @(negedge clk);
        ce = 1'b0;
        p1 = 1'b0;
        pos = 32'h00000000;
        repeat (2) @(negedge clk);
        p1 = 1'b1;
        @(negedge clk);
        ce = 1'b1;
        rd(pel_pkg::IDX_P1_FALL);
        check(rdata, a);
        rd(pel_pkg::IDX_P1_RISE);
        check(rdata, b);
        $display("test clock_enable done");
        // reset in mid-run clears captures and flags
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            rd(pel_pkg::IDX_P1_RISE + 16'(i));
            check(rdata, 32'h00000000);
        end
        rd(pel_pkg::IDX_PROBE_STAT);
        check(rdata, 32'h00000080);
        $display("test midrun_reset done");
        end_sim();
    end
endmodule
